/* hsura_defs.svh */
/*
 * Constants of the host register access block: strap codes, register
 * addresses, reset values and baud generator figures.
 * Assumes nothing; included by the package and the design modules.
 */
`ifndef HSURA_DEFS_SVH
`define HSURA_DEFS_SVH

// ==========================================================================
// Interface select codes, {high strap, low strap}
`define HSURA_MODE_UART 2'h0
`define HSURA_MODE_I2C 2'h1
`define HSURA_MODE_SPI 2'h2
`define HSURA_MODE_I2CL 2'h3

// ==========================================================================
// Register space
`define HSURA_REG_COUNT 128
`define HSURA_ADDR_W 7
`define HSURA_FIFO_ADDR 7'h09
`define HSURA_RATE_ADDR 7'h1f
`define HSURA_RATE_RESET 8'h7a
`define HSURA_RW_READ 1'b1

// ==========================================================================
// Baud generator: reference in kHz, core clock period in ns
`define HSURA_REF_KHZ 27120
`define HSURA_CLK_NS 100
`define HSURA_MILLI 1000
// Reference ticks per core cycle, in thousandths of a tick
`define HSURA_REF_STEP ((`HSURA_REF_KHZ * `HSURA_CLK_NS) / `HSURA_MILLI)
`define HSURA_ACC_W 23
`define HSURA_MANT_BIAS 33
`define HSURA_UART_LAST_BIT 4'h9
`define HSURA_UART_DATA_END 4'h8

// ==========================================================================
// Core cycles to wait after reset before the straps are trusted
`define HSURA_STRAP_WAIT 2'h3

`endif

/* hsura_host_if.sv */
/*
 * Host register access: strap decode, SPI slave and 8N1 UART front end
 * over a flip-flop register file.
 * Assumes a 10 MHz ref_clk, an external FIFO behind the FIFO address and
 * a pin multiplexer outside that routes the shared pins per mode.
 */

// Summary of operation
// - Two straps pick UART, SPI, I2C, I2C-L
// - Straps resampled after reset and power-down exit
// - SPI slave only, master clocks, up to 10 Mbit/s
// - SPI bytes shift MSB first
// - Device updates MISO on falling SCK edges
// - First SPI byte: address 7..1, bit 0 read
// - SPI read: address per byte, data one later
// - SPI write: data to incrementing addresses
// - FIFO address never increments during writes
// - UART starts at 115.2 kbit/s after reset
// - Exponent picks prescale, mantissa offset range
// - Bit rate formula from 27.12 MHz reference
// - Listed rate settings within 1.5 percent
// - UART frame: start, eight data, stop
// - UART bytes shift LSB first
// - UART read: address byte in, data out while pin four is high
// - UART write: address, data; address echoed
`timescale 1ns/1ps
`default_nettype none
`include "hsura_defs.svh"

module hsura_host_if #(
    parameter logic [`HSURA_ADDR_W-1:0] FIFO_ADDR = `HSURA_FIFO_ADDR,
    parameter logic [`HSURA_ADDR_W-1:0] RATE_ADDR = `HSURA_RATE_ADDR
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic iface_select_low_strap,
    input wire logic iface_select_high_strap,
    input wire logic power_down,
    input wire logic spi_sck,
    input wire logic chip_select_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic uart_rx,
    output logic uart_tx,
    input wire logic iface_pin_four,
    input wire logic [7:0] fifo_rd_data,
    output var hsura_pkg::hsura_wr_t reg_wr,
    output logic reg_rd_strobe,
    output logic [`HSURA_ADDR_W-1:0] reg_rd_addr,
    output var hsura_pkg::hsura_mode_t iface_mode,
    output logic [7:0] uart_rate_register
);

    // ======================================================================
    // Helpers

    // Bit period in thousandths of a reference tick
    function automatic logic [`HSURA_ACC_W-1:0] bit_period(
        input logic [7:0] rate
    );
        logic [12:0] ticks;
        ticks = 13'h0000;
        if (rate[7:5] == 3'h0) begin
            ticks = 13'(rate[4:0]) + 13'h0001;
        end else begin
            ticks = (13'(rate[4:0]) + 13'(`HSURA_MANT_BIAS))
                << (rate[7:5] - 3'h1);
        end
        return `HSURA_ACC_W'(ticks) * `HSURA_ACC_W'(`HSURA_MILLI);
    endfunction

    function automatic hsura_pkg::hsura_state_t reset_state();
        hsura_pkg::hsura_state_t r;
        r = '0;
        r.regs[RATE_ADDR] = `HSURA_RATE_RESET;
        r.strap_pending = `HSURA_STRAP_WAIT;
        r.link_clear = 1'b1;
        r.mode = hsura_pkg::HSURA_UART;
        r.ust = hsura_pkg::HSURA_U_IDLE;
        r.tx_sh = 10'h3ff;
        return r;
    endfunction

    localparam hsura_pkg::hsura_state_t RST = reset_state();
    localparam logic [`HSURA_ACC_W-1:0] STEP = `HSURA_ACC_W'(`HSURA_REF_STEP);

    // ======================================================================
    // State
    hsura_pkg::hsura_state_t s;
    hsura_pkg::hsura_state_t n;
    hsura_pkg::hsura_spi_byte_t spi_byte;
    logic spi_toggle;

    hsura_spi_link u_link (
        .spi_sck(spi_sck),
        .chip_select_n(chip_select_n),
        .spi_mosi(spi_mosi),
        .link_clear(s.link_clear),
        .tx_byte(s.miso_data),
        .spi_miso(spi_miso),
        .rx_byte(spi_byte),
        .rx_toggle(spi_toggle)
    );

    // ======================================================================
    // Next state
    always_comb begin
        logic [`HSURA_ACC_W-1:0] per;
        logic [`HSURA_ACC_W-1:0] acc_n;
        logic [`HSURA_ADDR_W-1:0] a;
        logic rd;
        logic got;
        logic [7:0] gb;
        logic tx_go;
        logic [7:0] tx_d;
        per = bit_period(s.regs[RATE_ADDR]);
        acc_n = '0;
        a = '0;
        rd = 1'b0;
        got = 1'b0;
        gb = 8'h00;
        tx_go = 1'b0;
        tx_d = 8'h00;
        n = s;

        // Two-stage synchronisers for every pin from outside the domain
        n.pd_sync = {s.pd_sync[0], power_down};
        n.strap_lo_sync = {s.strap_lo_sync[0], iface_select_low_strap};
        n.strap_hi_sync = {s.strap_hi_sync[0], iface_select_high_strap};
        n.pin4_sync = {s.pin4_sync[0], iface_pin_four};
        n.rx_sync = {s.rx_sync[0], uart_rx};
        n.tog_sync = {s.tog_sync[1:0], spi_toggle};
        n.wr = '0;
        n.rd_stb = 1'b0;
        n.link_clear = 1'b0;

        if (s.pd_sync[1]) begin
            // Interface held idle and re-armed for a fresh strap sample
            n.strap_pending = `HSURA_STRAP_WAIT;
            n.link_clear = 1'b1;
            n.spi_read = 1'b0;
            n.rx_busy = 1'b0;
            n.tx_busy = 1'b0;
            n.tx_sh = 10'h3ff;
            n.ust = hsura_pkg::HSURA_U_IDLE;
        end else if (s.strap_pending != 2'h0) begin
            n.link_clear = 1'b1;
            n.strap_pending = s.strap_pending - 2'h1;
            if (s.strap_pending == 2'h1) begin
                n.mode = hsura_pkg::hsura_mode_t'(
                    {s.strap_hi_sync[1], s.strap_lo_sync[1]});
            end
        end else if (s.mode == hsura_pkg::HSURA_SPI) begin
            // ==============================================================
            // SPI byte handling, one byte per toggle
            if (s.tog_sync[2] != s.tog_sync[1]) begin
                if (spi_byte.first) begin
                    n.spi_read = (spi_byte.data[0] == `HSURA_RW_READ);
                    n.spi_addr = spi_byte.data[7:1];
                    rd = (spi_byte.data[0] == `HSURA_RW_READ);
                end else if (s.spi_read) begin
                    n.spi_addr = spi_byte.data[7:1];
                    rd = 1'b1;
                end else begin
                    n.wr = '{strobe: 1'b1, addr: s.spi_addr,
                        data: spi_byte.data};
                    if (s.spi_addr != FIFO_ADDR) begin
                        n.spi_addr = s.spi_addr + 7'h01;
                    end
                end
                if (rd) begin
                    // Answer shows up one byte later on MISO
                    n.miso_data = (n.spi_addr == FIFO_ADDR) ? fifo_rd_data
                        : s.regs[n.spi_addr];
                    n.rd_stb = 1'b1;
                    n.rd_addr = n.spi_addr;
                end
            end
        end else if (s.mode == hsura_pkg::HSURA_UART) begin
            // ==============================================================
            // UART receiver, sampled mid-bit
            if (!s.rx_busy) begin
                if (!s.rx_sync[1]) begin
                    n.rx_busy = 1'b1;
                    n.rx_acc = per >> 1;
                    n.rx_bit = 4'h0;
                end
            end else begin
                acc_n = s.rx_acc + STEP;
                if (acc_n >= per) begin
                    n.rx_acc = acc_n - per;
                    n.rx_bit = s.rx_bit + 4'h1;
                    if (s.rx_bit == 4'h0) begin
                        // A glitch shorter than half a bit is no start
                        n.rx_busy = !s.rx_sync[1];
                    end else if (s.rx_bit <= `HSURA_UART_DATA_END) begin
                        n.rx_sh = {s.rx_sync[1], s.rx_sh[7:1]};
                    end else begin
                        n.rx_busy = 1'b0;
                        got = s.rx_sync[1];
                        gb = s.rx_sh;
                    end
                end else begin
                    n.rx_acc = acc_n;
                end
            end

            // ==============================================================
            // UART command sequencing
            if (got) begin
                case (s.ust)
                    hsura_pkg::HSURA_U_IDLE: begin
                        a = gb[7:1];
                        if (gb[0] == `HSURA_RW_READ) begin
                            if (s.pin4_sync[1]) begin
                                tx_go = 1'b1;
                                tx_d = (a == FIFO_ADDR) ? fifo_rd_data
                                    : s.regs[a];
                                n.rd_stb = 1'b1;
                                n.rd_addr = a;
                            end
                        end else begin
                            n.u_addr = a;
                            n.ust = hsura_pkg::HSURA_U_DATA;
                            tx_go = 1'b1;
                            tx_d = gb;
                        end
                    end
                    hsura_pkg::HSURA_U_DATA: begin
                        // May land while the echo is still going out
                        n.wr = '{strobe: 1'b1, addr: s.u_addr,
                            data: gb};
                        n.ust = hsura_pkg::HSURA_U_IDLE;
                    end
                    default: begin
                        n.ust = hsura_pkg::HSURA_U_IDLE;
                    end
                endcase
            end

            // ==============================================================
            // UART transmitter; a byte offered while busy is dropped
            if (tx_go && !s.tx_busy) begin
                n.tx_busy = 1'b1;
                n.tx_sh = {1'b1, tx_d, 1'b0};
                n.tx_acc = '0;
                n.tx_bit = 4'h0;
            end else if (s.tx_busy) begin
                acc_n = s.tx_acc + STEP;
                if (acc_n >= per) begin
                    n.tx_acc = acc_n - per;
                    n.tx_sh = {1'b1, s.tx_sh[9:1]};
                    n.tx_bit = s.tx_bit + 4'h1;
                    if (s.tx_bit == `HSURA_UART_LAST_BIT) begin
                        n.tx_busy = 1'b0;
                    end
                end else begin
                    n.tx_acc = acc_n;
                end
            end
        end

        // Register file write port shared by both front ends
        if (n.wr.strobe) begin
            n.regs[n.wr.addr] = n.wr.data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s <= RST;
        end else begin
            s <= n;
        end
    end

    // ======================================================================
    // Outputs
    assign uart_tx = s.tx_sh[0];
    assign spi_miso_oe = !chip_select_n && (s.mode == hsura_pkg::HSURA_SPI);
    assign reg_wr = s.wr;
    assign reg_rd_strobe = s.rd_stb;
    assign reg_rd_addr = s.rd_addr;
    assign iface_mode = s.mode;
    assign uart_rate_register = s.regs[RATE_ADDR];

endmodule // hsura_host_if

`default_nettype wire

/* hsura_host_if_checker.sv */
/* Checker of the host register access block: timing relations at its ports.
   Assumes it is bound onto hsura_host_if and sees nothing but its ports. */
`timescale 1ns/1ps
`default_nettype none
`include "hsura_defs.svh"

module hsura_host_if_checker #(
    parameter logic [`HSURA_ADDR_W-1:0] FIFO_ADDR = `HSURA_FIFO_ADDR,
    parameter logic [`HSURA_ADDR_W-1:0] RATE_ADDR = `HSURA_RATE_ADDR
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic chip_select_n,
    input wire logic spi_miso_oe,
    input wire logic uart_tx,
    input wire logic reg_rd_strobe,
    input wire hsura_pkg::hsura_wr_t reg_wr,
    input wire hsura_pkg::hsura_mode_t iface_mode,
    input wire logic [7:0] uart_rate_register
);
    // ==========
    // Helper state: last write of the current SPI transfer
    logic [`HSURA_ADDR_W-1:0] prev_addr_reg;
    logic seen_reg;
    logic [7:0] rate_data_reg;

    always_ff @(posedge ref_clk) begin
        if (reset || chip_select_n) seen_reg <= 1'b0;
        else if (reg_wr.strobe) seen_reg <= 1'b1;
        if (reg_wr.strobe) prev_addr_reg <= reg_wr.addr;
        if (reg_wr.strobe) rate_data_reg <= reg_wr.data;
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    // ==========
    // Assertions
    a_miso_drive_spi: assert property (
        spi_miso_oe == (iface_mode == hsura_pkg::HSURA_SPI && !chip_select_n))
        else $error("miso enable outside a selected SPI transfer");
    a_addr_step_fifo: assert property (
        reg_wr.strobe && seen_reg && iface_mode == hsura_pkg::HSURA_SPI |->
        reg_wr.addr == ((prev_addr_reg == FIFO_ADDR) ? prev_addr_reg : prev_addr_reg + 7'h01))
        else $error("SPI write address did not step as expected");
    a_wr_one_cycle: assert property (reg_wr.strobe |=> !reg_wr.strobe)
        else $error("write strobe longer than one cycle");
    a_rd_one_cycle: assert property (reg_rd_strobe |=> !reg_rd_strobe)
        else $error("read strobe longer than one cycle");
    a_rate_follows_write: assert property (
        (reg_wr.strobe && reg_wr.addr == RATE_ADDR) |=> ##[0:1] uart_rate_register == rate_data_reg)
        else $error("rate register missed its write");
    a_rate_held: assert property (
        $changed(uart_rate_register) |->
        reg_wr.strobe || $past(reg_wr.strobe) || $past(reg_wr.strobe, 2))
        else $error("rate register changed without a write");
    a_access_known_mode: assert property (
        (reg_wr.strobe || reg_rd_strobe) |->
        iface_mode inside {hsura_pkg::HSURA_UART, hsura_pkg::HSURA_SPI})
        else $error("register access in a mode without logic");
    a_tx_idle_other: assert property (iface_mode != hsura_pkg::HSURA_UART |-> uart_tx)
        else $error("uart transmit active outside UART mode");
    a_start_bit_len: assert property ($fell(uart_tx) |-> !uart_tx [*7])
        else $error("uart low bit shorter than a bit period");

    c_fifo_write: cover property (reg_wr.strobe && reg_wr.addr == FIFO_ADDR);
    c_reg_read: cover property (reg_rd_strobe);
    c_uart_frame: cover property ($fell(uart_tx));
endmodule // hsura_host_if_checker

bind hsura_host_if hsura_host_if_checker #(.FIFO_ADDR(FIFO_ADDR), .RATE_ADDR(RATE_ADDR)) chk_u (
    .ref_clk(ref_clk), .reset(reset), .chip_select_n(chip_select_n),
    .spi_miso_oe(spi_miso_oe), .uart_tx(uart_tx), .reg_rd_strobe(reg_rd_strobe),
    .reg_wr(reg_wr), .iface_mode(iface_mode), .uart_rate_register(uart_rate_register));
`default_nettype wire

/* hsura_host_if_test.sv */
/* Self-checking bench of hsura_host_if: strap rows, then SPI and UART
   register traffic through the host model.
   Assumes the design, the checker and the host model compile first. */
`timescale 1ns/1ps
`default_nettype none
`include "hsura_defs.svh"

`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end

module hsura_host_if_test;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic strap_lo = 1'b0;
    logic strap_hi = 1'b0;
    logic power_down = 1'b0;
    logic pin_four = 1'b1;
    logic [7:0] fifo_data = 8'h5a;
    logic sck, cs_n, mosi, miso, miso_oe, urx, utx, rd_stb;
    logic [6:0] rd_addr;
    logic [7:0] rate;
    hsura_pkg::hsura_wr_t reg_wr;
    hsura_pkg::hsura_mode_t mode;
    int compares = 0;
    int miscompares = 0;
    int tx_falls = 0;
    int n;
    logic [14:0] wq[$];
    logic [6:0] rq[$];
    logic [23:0] rx;
    realtime bp;
    // Rows: {high strap, low strap, expected mode}
    logic [3:0] rows [4] = '{{2'b01, `HSURA_MODE_I2C}, {2'b11, `HSURA_MODE_I2CL},
        {2'b00, `HSURA_MODE_UART}, {2'b10, `HSURA_MODE_SPI}};
    logic [7:0] rates [2] = '{8'h5a, 8'h15};

    initial forever #50 ref_clk = ~ref_clk;

    hsura_host_if dut_u (.ref_clk(ref_clk), .reset(reset), .iface_select_low_strap(strap_lo),
        .iface_select_high_strap(strap_hi), .power_down(power_down), .spi_sck(sck),
        .chip_select_n(cs_n), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe),
        .uart_rx(urx), .uart_tx(utx), .iface_pin_four(pin_four), .fifo_rd_data(fifo_data),
        .reg_wr(reg_wr), .reg_rd_strobe(rd_stb), .reg_rd_addr(rd_addr), .iface_mode(mode),
        .uart_rate_register(rate));

    hsura_host_model host_u (.spi_sck(sck), .chip_select_n(cs_n), .spi_mosi(mosi),
        .spi_miso(miso), .uart_rx(urx), .uart_tx(utx));

    always @(posedge ref_clk) if (reg_wr.strobe === 1'b1) wq.push_back({reg_wr.addr, reg_wr.data});
    always @(posedge ref_clk) if (rd_stb === 1'b1) rq.push_back(rd_addr);
    always @(negedge utx) tx_falls++;

    // ==========
    // Helpers
    function automatic realtime bit_ns(input logic [7:0] r);
        int p;
        p = (r[7:5] == 3'h0) ? r[4:0] + 1 : (r[4:0] + 33) << (r[7:5] - 1);
        return p * 1.0e6 / `HSURA_REF_KHZ;
    endfunction

    task automatic spi3(input logic [23:0] tx, output logic [23:0] rv);
        host_u.spi_sel(1'b1);
        for (int k = 2; k >= 0; k--) host_u.spi_byte(tx[k*8 +: 8], rv[k*8 +: 8]);
        host_u.spi_sel(1'b0);
    endtask

    task automatic uart_wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] e;
        logic s;
        fork
            begin
                host_u.uart_put(a, bp);
                host_u.uart_put(d, bp);
            end
            host_u.uart_get(e, s, bp);
        join
        `CHK("echo", a, e)
        `CHK("echo stop", 1'b1, s)
    endtask

    task automatic uart_rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic s;
        fork
            host_u.uart_put(a, bp);
            host_u.uart_get(d, s, bp);
        join
        `CHK("uart read", exp, d)
    endtask

    task automatic test_done();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ==========
    // Main sequence
    initial begin
        for (int r = 0; r < 4; r++) begin
            @(posedge ref_clk);
            {strap_hi, strap_lo} <= rows[r][3:2];
            reset <= 1'b1;
            repeat (8) @(posedge ref_clk);
            reset <= 1'b0;
            repeat (6) @(posedge ref_clk);
            #1;
            `CHK("mode", rows[r][1:0], mode)
            `CHK("rate reset", 8'h7a, rate)
        end
        spi3(24'h0a1122, rx);
        spi3(24'h123344, rx);
        `CHK("spi writes", {7'h05, 8'h11, 7'h06, 8'h22}, {wq[0], wq[1]})
        `CHK("fifo writes", {7'h09, 8'h33, 7'h09, 8'h44}, {wq[2], wq[3]})
        spi3(24'h0b1300, rx);
        `CHK("spi read", 16'h115a, rx[15:0])
        `CHK("spi read addr", {7'h05, 7'h09}, {rq[0], rq[1]})
        // Power-down exit must pick up the new straps
        @(posedge ref_clk);
        {strap_hi, strap_lo} <= 2'b00;
        power_down <= 1'b1;
        repeat (4) @(posedge ref_clk);
        power_down <= 1'b0;
        repeat (8) @(posedge ref_clk);
        #1;
        `CHK("mode after wake", `HSURA_MODE_UART, mode)
        bp = bit_ns(rate);
        uart_wr(8'h0a, 8'hab);
        repeat (2) @(posedge ref_clk);
        #1;
        `CHK("uart write", {7'h05, 8'hab}, wq[$])
        @(posedge ref_clk);
        pin_four <= 1'b0;
        n = tx_falls;
        host_u.uart_put(8'h0b, bp);
        #(bp * 12);
        `CHK("read refused", n, tx_falls)
        @(posedge ref_clk);
        pin_four <= 1'b1;
        repeat (4) @(posedge ref_clk);
        uart_rd(8'h0b, 8'hab);
        foreach (rates[i]) begin
            uart_wr(8'h3e, rates[i]);
            repeat (3) @(posedge ref_clk);
            #1;
            `CHK("rate", rates[i], rate)
            bp = bit_ns(rates[i]);
            uart_rd(8'h0b, 8'hab);
        end
        test_done();
    end

    initial begin
        #3ms;
        miscompares++;
        $display("ERROR watchdog expected done seen timeout");
        test_done();
    end
endmodule // hsura_host_if_test
`default_nettype wire

/* hsura_host_model.sv */
/* Host controller model: SPI master in mode 0 and an 8N1 UART host.
   Assumes the bench runs one task at a time on each interface. */
`timescale 1ns/1ps
`default_nettype none

module hsura_host_model (
    output logic spi_sck,
    output logic chip_select_n,
    output logic spi_mosi,
    input wire logic spi_miso,
    output logic uart_rx,
    input wire logic uart_tx
);
    initial begin
        spi_sck = 1'b0;
        chip_select_n = 1'b1;
        spi_mosi = 1'b0;
        uart_rx = 1'b1;
    end

    // ==========
    // SPI master; deselect flips MOSI so stale data never looks valid
    task automatic spi_sel(input logic sel);
        chip_select_n = ~sel;
        if (!sel) spi_mosi = ~spi_mosi;
        #300;
    endtask

    task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spi_mosi = tx[i];
            #3 spi_sck = 1'b1;
            rx[i] = spi_miso;
            #3 spi_sck = 1'b0;
        end
        // Core needs this gap to act on the byte, there is no buffer
        #1000;
    endtask

    // ==========
    // UART host
    task automatic uart_put(input logic [7:0] d, input realtime bp);
        uart_rx = 1'b0;
        #bp;
        for (int i = 0; i < 8; i++) begin
            uart_rx = d[i];
            #bp;
        end
        uart_rx = 1'b1;
        #bp;
    endtask

    task automatic uart_get(output logic [7:0] d, output logic stop, input realtime bp);
        @(negedge uart_tx);
        #(bp / 2.0);
        for (int i = 0; i < 8; i++) begin
            #bp;
            d[i] = uart_tx;
        end
        #bp;
        stop = uart_tx;
    endtask
endmodule // hsura_host_model
`default_nettype wire

/* hsura_pkg.sv */
/*
 * Types of the host register access block.
 * Assumes hsura_defs.svh is on the include path.
 */
`default_nettype none
`include "hsura_defs.svh"

package hsura_pkg;

    // ======================================================================
    // Modes and protocol states
    typedef enum logic [1:0] {
        HSURA_UART = `HSURA_MODE_UART,
        HSURA_I2C = `HSURA_MODE_I2C,
        HSURA_SPI = `HSURA_MODE_SPI,
        HSURA_I2CL = `HSURA_MODE_I2CL
    } hsura_mode_t;

    typedef enum logic [1:0] {
        HSURA_U_IDLE = 2'h1,
        HSURA_U_DATA = 2'h2
    } hsura_ust_t;

    // ======================================================================
    // Carriers
    typedef struct packed {
        logic first;
        logic [7:0] data;
    } hsura_spi_byte_t;

    typedef struct packed {
        logic strobe;
        logic [`HSURA_ADDR_W-1:0] addr;
        logic [7:0] data;
    } hsura_wr_t;

    typedef struct packed {
        logic [2:0] count;
        logic first;
        logic [6:0] in_sh;
        logic [6:0] tx_sh;
    } hsura_link_t;

    typedef struct packed {
        logic [1:0] pd_sync;
        logic [1:0] strap_lo_sync;
        logic [1:0] strap_hi_sync;
        logic [1:0] pin4_sync;
        logic [1:0] rx_sync;
        logic [2:0] tog_sync;
        logic link_clear;
        logic [1:0] strap_pending;
        hsura_mode_t mode;
        logic [`HSURA_REG_COUNT-1:0][7:0] regs;
        logic [`HSURA_ADDR_W-1:0] spi_addr;
        logic spi_read;
        logic [7:0] miso_data;
        logic rx_busy;
        logic [`HSURA_ACC_W-1:0] rx_acc;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        logic tx_busy;
        logic [`HSURA_ACC_W-1:0] tx_acc;
        logic [3:0] tx_bit;
        logic [9:0] tx_sh;
        hsura_ust_t ust;
        logic [`HSURA_ADDR_W-1:0] u_addr;
        hsura_wr_t wr;
        logic rd_stb;
        logic [`HSURA_ADDR_W-1:0] rd_addr;
    } hsura_state_t;

endpackage

`default_nettype wire

/* hsura_spi_link.sv */
/*
 * SPI slave shifter running on the host's serial clock.
 * Assumes mode-0 clocking and a core that consumes each byte by a toggle
 * and presents the next answer byte on tx_byte before the next byte starts.
 */
`timescale 1ns/1ps
`default_nettype none
`include "hsura_defs.svh"

module hsura_spi_link (
    input wire logic spi_sck,
    input wire logic chip_select_n,
    input wire logic spi_mosi,
    input wire logic link_clear,
    input wire logic [7:0] tx_byte,
    output logic spi_miso,
    output var hsura_pkg::hsura_spi_byte_t rx_byte,
    output logic rx_toggle
);

    // ======================================================================
    // Bit counter and shifters, cleared while deselected
    localparam hsura_pkg::hsura_link_t LINK_RST = '{
        count: 3'h0, first: 1'b1, in_sh: 7'h00, tx_sh: 7'h00};

    hsura_pkg::hsura_link_t s;
    hsura_pkg::hsura_link_t n;
    logic miso_q;
    logic miso_live;

    always_comb begin
        n = s;
        n.count = s.count + 3'h1;
        n.in_sh = {s.in_sh[5:0], spi_mosi};
        if (s.count == 3'h0) begin
            n.tx_sh = tx_byte[6:0];
        end else begin
            n.tx_sh = {s.tx_sh[5:0], 1'b0};
        end
        if (s.count == 3'h7) begin
            n.first = 1'b0;
        end
    end

    // Sampling on the rising edge
    always_ff @(posedge spi_sck or posedge chip_select_n) begin
        if (chip_select_n) begin
            s <= LINK_RST;
        end else begin
            s <= n;
        end
    end

    // ======================================================================
    // Byte hand-off; cleared only by the core so no toggle is lost
    always_ff @(posedge spi_sck or posedge link_clear) begin
        if (link_clear) begin
            rx_byte <= '0;
            rx_toggle <= 1'b0;
        end else if (s.count == 3'h7) begin
            rx_byte <= '{first: s.first, data: {s.in_sh, spi_mosi}};
            rx_toggle <= ~rx_toggle;
        end
    end

    // ======================================================================
    // Answer bits change on the falling edge
    always_ff @(negedge spi_sck or posedge chip_select_n) begin
        if (chip_select_n) begin
            miso_q <= 1'b0;
            miso_live <= 1'b0;
        end else begin
            miso_q <= s.tx_sh[6];
            miso_live <= (s.count != 3'h0);
        end
    end

    // First bit comes straight from the held core byte, so the core has
    // the whole gap between bytes to fetch it.
    // The switch to the shifter waits for the first falling edge, so
    // nothing moves at the edge where the master samples.
    assign spi_miso = miso_live ? miso_q : tx_byte[7];

endmodule // hsura_spi_link

`default_nettype wire
